// [rtl/lvdp_map.svh]
`ifndef LVDP_MAP_SVH
`define LVDP_MAP_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define LVDP_DRV_IDX    10'h063
`define LVDP_PHS_IDX    10'h064
`define LVDP_STAT_IDX   10'h080

// ==========================================================================
// Reset values
`define LVDP_DRV_RST    8'h01
`define LVDP_PHS_RST    8'h03

// ==========================================================================
// Field positions
`define LVDP_LOAD_BIT   3
`define LVDP_CUR_MSB    2
`define LVDP_CUR_LSB    0
`define LVDP_PH_EN_BIT  7
`define LVDP_PH_MSB     6
`define LVDP_PH_LSB     4
`define LVDP_ST_EN_BIT  0
`define LVDP_ST_PH_MSB  3
`define LVDP_ST_PH_LSB  1
`define LVDP_ST_BAD_BIT 4
`define LVDP_ST_4PH_BIT 5
`define LVDP_FLT_MSB    8
`define LVDP_FLT_LSB    1
`define LVDP_FLT_A_BIT  6

// ==========================================================================
// Driver current codes and currents in microamps
`define LVDP_CUR_7P2    3'h7
`define LVDP_CUR_5P4    3'h3
`define LVDP_CUR_3P5    3'h1
`define LVDP_CUR_1P8    3'h0
`define LVDP_UA_7P2     13'h1C20
`define LVDP_UA_5P4     13'h1518
`define LVDP_UA_3P5     13'h0DAC
`define LVDP_UA_1P8     13'h0708
`define LVDP_UA_NONE    13'h0000

// ==========================================================================
// Phase and filter limits
`define LVDP_PH_DEFAULT 3'h0
`define LVDP_DEC_MIN    10'h002

// ==========================================================================
// AXI responses
`define LVDP_RESP_OKAY  2'h0
`define LVDP_RESP_SLV   2'h2

`endif

// [rtl/lvdp_phase.sv]
`include "lvdp_map.svh"

module lvdp_phase import lvdp_pkg::*; #(
  parameter int DEC_W = 10
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  // Configuration
  input  wire logic [7:0]       phase_cfg_i,
  input  wire logic [DEC_W-1:0] decim_factor_i,
  input  wire logic [8:0]       filter_stage_a_select_i,
  input  wire logic [8:0]       filter_stage_b_select_i,
  // Resolved clock phase
  output logic                  phase_active_o,
  output logic                  four_phase_o,
  output logic [2:0]            phase_code_o
);

  logic       enable;
  logic       dec_ok;
  logic       four;
  logic [2:0] req;
  logic [2:0] next_code;

  assign enable = phase_cfg_i[`LVDP_PH_EN_BIT];
  assign req    = phase_cfg_i[`LVDP_PH_MSB:`LVDP_PH_LSB];
  assign dec_ok = decim_factor_i > DEC_W'(`LVDP_DEC_MIN);
  assign four   = (filter_stage_a_select_i[`LVDP_FLT_MSB:`LVDP_FLT_LSB] == 8'h00) &&
                  (filter_stage_b_select_i[`LVDP_FLT_MSB:`LVDP_FLT_LSB] == 8'h00) &&
                  !filter_stage_a_select_i[`LVDP_FLT_A_BIT];

  // Even steps do not exist in four-phase mode; round up to the odd step
  always_comb begin
    next_code = `LVDP_PH_DEFAULT;
    if (enable && dec_ok) begin
      next_code = req;
      if (four && req != `LVDP_PH_DEFAULT) begin
        next_code = req | 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_code_o   <= 3'h0;
      phase_active_o <= 1'b0;
      four_phase_o   <= 1'b0;
    end else begin
      phase_code_o   <= next_code;
      phase_active_o <= enable && dec_ok;
      four_phase_o   <= four;
    end
  end

endmodule : lvdp_phase

// [rtl/lvdp_pkg.sv]
package lvdp_pkg;

  // ==========================================================================
  // Register select
  typedef enum logic [1:0] {
    LVDP_SEL_NONE = 2'b00,
    LVDP_SEL_DRV  = 2'b01,
    LVDP_SEL_PHS  = 2'b10,
    LVDP_SEL_STAT = 2'b11
  } lvdp_sel_t;

endpackage : lvdp_pkg

// [rtl/lvdp_regs.sv]
// Operation
// - Driver register bit 3 set turns on internal LVDS load termination.
// - Current code 111/011/001/000 gives 7.2/5.4/3.5/1.8 mA.
// - Phase register bit 7 enables output clock phase delay control.
// - Phase field bits 6..4 shift the output clock by code times 45 degrees.
// - Phase field is ignored while the enable bit is zero.
// - Non-default shifts apply only when decimation factor exceeds two.
// - With filter selects zero only +45, +135, +225, +315 exist.
// - Every non-zero phase code is an offset from the code 000 phase.
//
// Register access over AXI4-Lite was chosen for this implementation.
`include "lvdp_map.svh"

module lvdp_regs import lvdp_pkg::*; #(
  parameter int ADDR_W = 12,
  parameter int DEC_W  = 10
) (
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // Filter configuration
  input  wire logic [DEC_W-1:0]  decim_factor_i,
  input  wire logic [8:0]        filter_stage_a_select_i,
  input  wire logic [8:0]        filter_stage_b_select_i,
  // Output driver
  output logic                   lvds_load_en_o,
  output logic [2:0]             driver_current_select_o,
  output logic [12:0]            drive_current_ua_o,
  output logic                   drive_current_bad_o,
  // Output clock phase
  output logic                   clock_phase_delay_enable_o,
  output logic [2:0]             decimated_clock_phase_select_o
);

  // ==========================================================================
  // Decoding
  function automatic lvdp_sel_t lvdp_decode(input logic [ADDR_W-1:0] addr);
    lvdp_sel_t sel;
    sel = LVDP_SEL_NONE;
    if (addr == ADDR_W'({`LVDP_DRV_IDX, 2'b00})) begin
      sel = LVDP_SEL_DRV;
    end else if (addr == ADDR_W'({`LVDP_PHS_IDX, 2'b00})) begin
      sel = LVDP_SEL_PHS;
    end else if (addr == ADDR_W'({`LVDP_STAT_IDX, 2'b00})) begin
      sel = LVDP_SEL_STAT;
    end
    return sel;
  endfunction : lvdp_decode

  function automatic logic [12:0] lvdp_current_ua(input logic [2:0] code);
    logic [12:0] ua;
    ua = `LVDP_UA_NONE;
    case (code)
      `LVDP_CUR_7P2: ua = `LVDP_UA_7P2;
      `LVDP_CUR_5P4: ua = `LVDP_UA_5P4;
      `LVDP_CUR_3P5: ua = `LVDP_UA_3P5;
      `LVDP_CUR_1P8: ua = `LVDP_UA_1P8;
      default:       ua = `LVDP_UA_NONE;
    endcase
    return ua;
  endfunction : lvdp_current_ua

  // ==========================================================================
  // Write channel
  logic              aw_held;
  logic [ADDR_W-1:0] aw_addr;
  logic              w_held;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_go;
  lvdp_sel_t         wr_sel;
  logic              wr_drv;
  logic              wr_phs;

  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
  assign wr_go  = aw_held && w_held && !s_axi_bvalid_o;
  assign wr_sel = lvdp_decode(aw_addr);
  // Only byte lane 0 holds register bits
  assign wr_drv = wr_go && wr_sel == LVDP_SEL_DRV && w_strb[0];
  assign wr_phs = wr_go && wr_sel == LVDP_SEL_PHS && w_strb[0];

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_i;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `LVDP_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_o <= 1'b1;
      // Status register is read only; a write there is refused too
      s_axi_bresp_o  <= (wr_sel == LVDP_SEL_DRV || wr_sel == LVDP_SEL_PHS) ?
                        `LVDP_RESP_OKAY : `LVDP_RESP_SLV;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ==========================================================================
  // Configuration registers
  logic [7:0] drv_cfg;
  logic [7:0] phs_cfg;

  // Whole byte is stored, trim nibble included, so software can restore it
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      drv_cfg <= `LVDP_DRV_RST;
    end else if (wr_drv) begin
      drv_cfg <= w_data[7:0];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phs_cfg <= `LVDP_PHS_RST;
    end else if (wr_phs) begin
      phs_cfg <= w_data[7:0];
    end
  end

  // ==========================================================================
  // Output driver
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lvds_load_en_o          <= 1'b0;
      driver_current_select_o <= `LVDP_CUR_3P5;
      drive_current_ua_o      <= `LVDP_UA_3P5;
      drive_current_bad_o     <= 1'b0;
    end else begin
      lvds_load_en_o          <= drv_cfg[`LVDP_LOAD_BIT];
      driver_current_select_o <= drv_cfg[`LVDP_CUR_MSB:`LVDP_CUR_LSB];
      // Unsupported codes give no defined current
      drive_current_ua_o      <= lvdp_current_ua(drv_cfg[`LVDP_CUR_MSB:`LVDP_CUR_LSB]);
      drive_current_bad_o     <= lvdp_current_ua(drv_cfg[`LVDP_CUR_MSB:`LVDP_CUR_LSB])
                                 == `LVDP_UA_NONE;
    end
  end

  // ==========================================================================
  // Output clock phase
  logic four_phase;

  lvdp_phase #(
    .DEC_W(DEC_W)
  ) u_phase (
    .ref_clk_i               (ref_clk_i),
    .rst_i                   (rst_i),
    .phase_cfg_i             (phs_cfg),
    .decim_factor_i          (decim_factor_i),
    .filter_stage_a_select_i (filter_stage_a_select_i),
    .filter_stage_b_select_i (filter_stage_b_select_i),
    .phase_active_o          (clock_phase_delay_enable_o),
    .four_phase_o            (four_phase),
    .phase_code_o            (decimated_clock_phase_select_o)
  );

  // ==========================================================================
  // Read channel
  lvdp_sel_t  rd_sel;
  logic [7:0] rd_byte;

  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign rd_sel = lvdp_decode(s_axi_araddr_i);

  always_comb begin
    rd_byte = 8'h00;
    if (rd_sel == LVDP_SEL_DRV) begin
      rd_byte = drv_cfg;
    end else if (rd_sel == LVDP_SEL_PHS) begin
      rd_byte = phs_cfg;
    end else if (rd_sel == LVDP_SEL_STAT) begin
      rd_byte[`LVDP_ST_EN_BIT]                 = clock_phase_delay_enable_o;
      rd_byte[`LVDP_ST_PH_MSB:`LVDP_ST_PH_LSB] = decimated_clock_phase_select_o;
      rd_byte[`LVDP_ST_BAD_BIT]                = drive_current_bad_o;
      rd_byte[`LVDP_ST_4PH_BIT]                = four_phase;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= `LVDP_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= {24'h00_0000, rd_byte};
      s_axi_rresp_o  <= (rd_sel == LVDP_SEL_NONE) ? `LVDP_RESP_SLV : `LVDP_RESP_OKAY;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  logic [2:0] req_ph;
  logic       dec_ok;
  logic       four_now;
  assign req_ph = phs_cfg[`LVDP_PH_MSB:`LVDP_PH_LSB];
  assign dec_ok = decim_factor_i > DEC_W'(`LVDP_DEC_MIN);
  // Unregistered mode; the registered flag lags the filter selects by a cycle, as the phase code does
  assign four_now = (filter_stage_a_select_i[`LVDP_FLT_MSB:`LVDP_FLT_LSB] == 8'h00) &&
                    (filter_stage_b_select_i[`LVDP_FLT_MSB:`LVDP_FLT_LSB] == 8'h00) &&
                    !filter_stage_a_select_i[`LVDP_FLT_A_BIT];

  a_load_after_write: assert property (
    wr_drv |-> ##2 (lvds_load_en_o == $past(w_data[`LVDP_LOAD_BIT], 2)))
    else $error("Load termination does not follow written bit");

  a_current_map: assert property (
    (drv_cfg[`LVDP_CUR_MSB:`LVDP_CUR_LSB] == `LVDP_CUR_7P2) |=>
    (drive_current_ua_o == `LVDP_UA_7P2))
    else $error("Current code 111 not mapped to 7.2 mA");

  a_current_default: assert property (
    (drv_cfg[`LVDP_CUR_MSB:`LVDP_CUR_LSB] == `LVDP_CUR_3P5) |=>
    (drive_current_ua_o == `LVDP_UA_3P5))
    else $error("Current code 001 not mapped to 3.5 mA");

  a_phase_disabled: assert property (
    !phs_cfg[`LVDP_PH_EN_BIT] |=> (decimated_clock_phase_select_o == 3'h0)
                                  && !clock_phase_delay_enable_o)
    else $error("Phase shift applied while disabled");

  a_phase_enable: assert property (
    $rose(phs_cfg[`LVDP_PH_EN_BIT]) && dec_ok && $stable(decim_factor_i)
    |=> clock_phase_delay_enable_o)
    else $error("Phase enable not reflected");

  a_phase_select: assert property (
    phs_cfg[`LVDP_PH_EN_BIT] && dec_ok && !four_now
    |=> (decimated_clock_phase_select_o == $past(req_ph)))
    else $error("Phase select differs from field");

  a_low_decim_default: assert property (
    !dec_ok |=> (decimated_clock_phase_select_o == 3'h0))
    else $error("Phase shift with decimation of two or less");

  a_four_phase_odd: assert property (
    four_phase && (decimated_clock_phase_select_o != 3'h0)
    |-> decimated_clock_phase_select_o[0])
    else $error("Even shift in four-phase mode");

  a_code_zero_ref: assert property (
    (req_ph == 3'h0) |=> (decimated_clock_phase_select_o == 3'h0))
    else $error("Code 000 does not give default phase");

  a_readback: assert property (
    s_axi_arvalid_i && s_axi_arready_o && rd_sel == LVDP_SEL_PHS && !wr_phs
    |=> s_axi_rvalid_o && (s_axi_rdata_o[7:0] == phs_cfg))
    else $error("Phase register read back wrong");

  c_write_drv:  cover property (wr_drv ##2 lvds_load_en_o);
  c_phase_on:   cover property (clock_phase_delay_enable_o
                                && decimated_clock_phase_select_o == 3'h7);
  c_four_phase: cover property (four_phase && clock_phase_delay_enable_o);
  c_bad_code:   cover property (drive_current_bad_o);

endmodule : lvdp_regs

// [sim/lvdp_host_model.sv]
module lvdp_host_model (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  // Output clock phase seen at the capture side
  input  wire logic       phase_en_i,
  input  wire logic [2:0] phase_code_i,
  // Measured shift in degrees from the code 000 phase
  output logic      [8:0] phase_deg_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Capture side only measures, it never pushes back on the device
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_deg_o <= 9'h000;
    end else begin
      phase_deg_o <= phase_en_i ? 9'(phase_code_i) * 9'h02D : 9'h000;
    end
  end
endmodule : lvdp_host_model

// [sim/lvds_drive_and_clock_phase_regs_tb.sv]
`include "lvdp_map.svh"

module lvds_drive_and_clock_phase_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Stimulus and observed signals
  logic        ref_clk = 1'h0;
  logic        rst     = 1'h1;
  logic [11:0] awaddr  = 12'h000;
  logic [11:0] araddr  = 12'h000;
  logic        awvalid = 1'h0;
  logic        wvalid  = 1'h0;
  logic        bready  = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready  = 1'h0;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [3:0]  wstrb   = 4'hF;
  logic [9:0]  decim   = 10'h004;
  logic [8:0]  fa      = 9'h002;
  logic [8:0]  fb      = 9'h000;
  logic        awready, wready, bvalid, arready, rvalid, load_en, bad, ph_en;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [2:0]  cur_sel, ph_code;
  logic [12:0] ua;
  logic [8:0]  ph_deg;
  int          num_errors      = 0;
  int          samples_checked = 0;
  localparam logic [11:0] DRV = {`LVDP_DRV_IDX, 2'h0};
  localparam logic [11:0] PHS = {`LVDP_PHS_IDX, 2'h0};
  localparam logic [11:0] STA = {`LVDP_STAT_IDX, 2'h0};

  always #50 ref_clk = ~ref_clk;

  lvdp_regs u_dut (
    .ref_clk_i(ref_clk), .rst_i(rst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .decim_factor_i(decim),
    .filter_stage_a_select_i(fa), .filter_stage_b_select_i(fb),
    .lvds_load_en_o(load_en), .driver_current_select_o(cur_sel),
    .drive_current_ua_o(ua), .drive_current_bad_o(bad),
    .clock_phase_delay_enable_o(ph_en), .decimated_clock_phase_select_o(ph_code)
  );

  lvdp_host_model u_host (
    .ref_clk_i(ref_clk), .rst_i(rst), .phase_en_i(ph_en),
    .phase_code_i(ph_code), .phase_deg_o(ph_deg)
  );

  // ==========================================================================
  // Shared tasks
  task automatic report_and_stop();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_done, w_done, aw_ok, w_ok;
    int   n;
    aw_done = 1'h0;
    w_done  = 1'h0;
    n       = 0;
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    // Ready is judged mid-cycle so the taking edge is never raced
    while (!(aw_done && w_done) && n < 50) begin
      @(negedge ref_clk);
      aw_ok = !aw_done && awready;
      w_ok  = !w_done && wready;
      @(posedge ref_clk);
      if (aw_ok) begin
        awvalid <= 1'h0;
        aw_done = 1'h1;
      end
      if (w_ok) begin
        wvalid <= 1'h0;
        w_done = 1'h1;
      end
      n++;
    end
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (!bvalid && n < 50);
    check("bvalid", 32'h1, bvalid);
    check("bresp", er, bresp);
    @(posedge ref_clk);
    bready <= 1'h0;
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic ok;
    int   n;
    ok = 1'h0;
    n  = 0;
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    while (!ok && n < 50) begin
      @(negedge ref_clk);
      ok = arready;
      @(posedge ref_clk);
      if (ok) begin
        arvalid <= 1'h0;
      end
      n++;
    end
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (!rvalid && n < 50);
    check("rvalid", 32'h1, rvalid);
    check("rdata", exp, rdata);
    check("rresp", er, rresp);
    @(posedge ref_clk);
    rready <= 1'h0;
  endtask : axi_read

  task automatic settle();
    repeat (3) @(negedge ref_clk);
  endtask : settle

  task automatic phase_case(input logic en, input logic [2:0] c, input logic [2:0] exp);
    axi_write(PHS, {en, c, 4'h3}, `LVDP_RESP_OKAY);
    settle();
    check("ph_code", exp, ph_code);
    check("ph_en", exp != 3'h0 || (en && decim > 10'h002), ph_en);
    check("ph_deg", 9'(exp) * 9'h02D, ph_deg);
  endtask : phase_case

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    axi_read(DRV, 32'h01, `LVDP_RESP_OKAY);
    axi_read(PHS, 32'h03, `LVDP_RESP_OKAY);
    check("load", 32'h0, load_en);
    check("cur", 32'h1, cur_sel);
    check("ua", `LVDP_UA_3P5, ua);
    check("ph_en", 32'h0, ph_en);
  endtask : t_reset

  task automatic t_current();
    logic [2:0]  codes [4] = '{3'h7, 3'h3, 3'h1, 3'h0};
    logic [12:0] uas   [4] = '{`LVDP_UA_7P2, `LVDP_UA_5P4, `LVDP_UA_3P5, `LVDP_UA_1P8};
    for (int i = 0; i < 4; i++) begin
      axi_write(DRV, {4'h0, 1'(i % 2 == 0), codes[i]}, `LVDP_RESP_OKAY);
      settle();
      check("load", i % 2 == 0, load_en);
      check("cur", codes[i], cur_sel);
      check("ua", uas[i], ua);
      check("bad", 32'h0, bad);
      axi_read(DRV, {4'h0, 1'(i % 2 == 0), codes[i]}, `LVDP_RESP_OKAY);
    end
    axi_read(PHS, 32'h03, `LVDP_RESP_OKAY);
  endtask : t_current

  task automatic t_phase();
    for (int c = 0; c < 8; c++) begin
      phase_case(1'h1, 3'(c), 3'(c));
    end
    phase_case(1'h0, 3'h5, 3'h0);
    axi_read(PHS, 32'h53, `LVDP_RESP_OKAY);
  endtask : t_phase

  task automatic t_decim();
    @(posedge ref_clk);
    decim <= 10'h002;
    phase_case(1'h1, 3'h6, 3'h0);
    @(posedge ref_clk);
    decim <= 10'h003;
    phase_case(1'h1, 3'h6, 3'h6);
  endtask : t_decim

  task automatic t_four();
    // All selects clear: only odd codes exist, even ones round up
    @(posedge ref_clk);
    fa <= 9'h000;
    phase_case(1'h1, 3'h2, 3'h3);
    phase_case(1'h1, 3'h5, 3'h5);
    axi_read(STA, 32'h2B, `LVDP_RESP_OKAY);
    @(posedge ref_clk);
    fb <= 9'h100;
    phase_case(1'h1, 3'h2, 3'h2);
  endtask : t_four

  task automatic t_bad_addr();
    axi_write(12'h1F0, 8'hAA, `LVDP_RESP_SLV);
    axi_write(STA, 8'hAA, `LVDP_RESP_SLV);
    axi_read(12'h1F0, 32'h0, `LVDP_RESP_SLV);
    // Lane 0 strobe low: accepted but the register keeps its value
    @(posedge ref_clk);
    wstrb <= 4'hE;
    axi_write(DRV, 8'h0F, `LVDP_RESP_OKAY);
    wstrb <= 4'hF;
    axi_read(DRV, 32'h00, `LVDP_RESP_OKAY);
  endtask : t_bad_addr

  // ==========================================================================
  // Sequence and watchdog
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    t_reset();
    t_current();
    t_phase();
    t_decim();
    t_four();
    t_bad_addr();
    report_and_stop();
  end

  initial begin
    // Whole sequence needs well under a thousand cycles
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    report_and_stop();
  end
endmodule : lvds_drive_and_clock_phase_regs_tb
